/* src/pxr_pkg.sv */
// Purpose: Constants for the extended capability register bank
// Assumes: Word-aligned byte addresses, 32-bit register data
// Notes: Shared by the bank and its helper modules
package pxr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [11:0] OFS_HDR_LOG_DW1 = 12'h11c;
    localparam logic [11:0] OFS_HDR_LOG_DW2 = 12'h120;
    localparam logic [11:0] OFS_HDR_LOG_DW3 = 12'h124;
    localparam logic [11:0] OFS_HDR_LOG_DW4 = 12'h128;
    localparam logic [11:0] OFS_SERIAL_HDR = 12'h180;
    localparam logic [11:0] OFS_SERIAL_LOW = 12'h184;
    localparam logic [11:0] OFS_SERIAL_HIGH = 12'h188;
    localparam logic [11:0] OFS_VCHAN_HDR = 12'h200;
    localparam logic [11:0] OFS_PORT_VCHAN_ONE = 12'h204;
    // Own control word: bit 0 locks the lockable fields, bits 12:8
    // show the first error pointer when read
    localparam logic [11:0] OFS_BANK_CTRL = 12'h300;
    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_FEP_LSB = 8;
    // Header field layout
    localparam logic [15:0] CAP_ID_SERIAL = 16'h0003;
    localparam logic [15:0] CAP_ID_VCHAN = 16'h0002;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [11:0] NEXT_PTR_RESET = 12'h000;
    // Port VC capability one fields
    localparam logic [2:0] EXT_CHAN_COUNT = 3'h0;
    localparam logic [2:0] LOW_PRIO_CHAN_COUNT = 3'h0;
    localparam logic [1:0] ARB_TIME_BASE = 2'h0;
    localparam logic [1:0] ENTRY_SIZE_1BIT = 2'h0;
    localparam logic [1:0] ENTRY_SIZE_2BIT = 2'h1;
    localparam logic [1:0] ENTRY_SIZE_4BIT = 2'h2;
    localparam logic [1:0] ENTRY_SIZE_8BIT = 2'h3;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [4:0] FEP_ZERO = 5'h00;
    localparam int HDR_WORDS = 4;

    // Builds an extended capability header word
    function automatic logic [31:0] cap_header(input logic [15:0] id,
                                               input logic [11:0] nxt);
        cap_header = {nxt, CAP_VERSION, id};
    endfunction : cap_header
endpackage : pxr_pkg

/* src/pxr_hdr_log.sv */
// Purpose: Sticky capture of the first uncorrectable error header
// Assumes: Capture pulse arrives with all four header words valid
// Notes: Only the first report is held until a sticky reset
`timescale 1ns/1ps
`default_nettype none
module pxr_hdr_log
    import pxr_pkg::*;
(
    input wire logic ref_clk_i,             // Core clock
    input wire logic sticky_rst_n_i,        // Sticky reset, active low
    input wire logic err_report_i,          // Uncorrectable error reported
    input wire logic [4:0] err_bit_i,       // Status bit of that error
    input wire logic [127:0] err_header_i,  // Header, word 1 in low bits
    output logic [127:0] log_o,             // Held header words
    output logic [4:0] fep_o                // First error pointer
);
    typedef struct packed {
        logic held;
        logic [127:0] log;
        logic [4:0] fep;
    } pxr_log_s;
    pxr_log_s st_ff;
    pxr_log_s nxt_st;

    // Later errors must not overwrite the first record
    always_comb
    begin
        nxt_st = st_ff;
        if (err_report_i && !st_ff.held)
        begin
            nxt_st.held = 1'b1;
            nxt_st.log = err_header_i;
            nxt_st.fep = err_bit_i;
        end
    end

    // Sticky state clears to zero only on sticky reset
    always_ff @(posedge ref_clk_i or negedge sticky_rst_n_i)
    begin
        if (!sticky_rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign log_o = st_ff.log;
    assign fep_o = st_ff.fep;

    chk_first_kept: assert property (@(posedge ref_clk_i)
        disable iff (!sticky_rst_n_i)
        st_ff.held |=> $stable(st_ff.log) && $stable(st_ff.fep))
        else $error("Header log changed after first capture");
    chk_capture_val: assert property (@(posedge ref_clk_i)
        disable iff (!sticky_rst_n_i)
        (err_report_i && !st_ff.held) |=>
            st_ff.log == $past(err_header_i)
            && st_ff.fep == $past(err_bit_i))
        else $error("Header log or pointer not captured");
endmodule : pxr_hdr_log
`default_nettype wire

/* src/pxr_serial_id.sv */
// Purpose: Lockable sticky 64-bit unique identifier store
// Assumes: Lock input holds writes off once firmware sets it
// Notes: Two word halves, each written independently
`timescale 1ns/1ps
`default_nettype none
module pxr_serial_id
    import pxr_pkg::*;
(
    input wire logic ref_clk_i,         // Core clock
    input wire logic sticky_rst_n_i,    // Sticky reset, active low
    input wire logic lock_i,            // Lockable fields read only
    input wire logic wr_low_i,          // Write lower half
    input wire logic wr_high_i,         // Write upper half
    input wire logic [31:0] wdata_i,    // Write data
    output logic [63:0] id_o            // Identifier
);
    typedef struct packed {
        logic [31:0] high;
        logic [31:0] low;
    } pxr_id_s;
    pxr_id_s st_ff;
    pxr_id_s nxt_st;

    // Writes land only while unlocked
    always_comb
    begin
        nxt_st = st_ff;
        if (wr_low_i && !lock_i)
            nxt_st.low = wdata_i;
        if (wr_high_i && !lock_i)
            nxt_st.high = wdata_i;
    end

    always_ff @(posedge ref_clk_i or negedge sticky_rst_n_i)
    begin
        if (!sticky_rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign id_o = {st_ff.high, st_ff.low};

    chk_lock_holds: assert property (@(posedge ref_clk_i)
        disable iff (!sticky_rst_n_i)
        lock_i |=> $stable(st_ff))
        else $error("Identifier changed while locked");
    chk_high_write: assert property (@(posedge ref_clk_i)
        disable iff (!sticky_rst_n_i)
        (wr_high_i && !lock_i) |=> st_ff.high == $past(wdata_i))
        else $error("Upper identifier write lost");
endmodule : pxr_serial_id
`default_nettype wire

/* src/pxr_cap_regs.sv */
// Purpose: Extended capability register bank for one switch port
// Assumes: Plain register port, read data valid one cycle after strobe
// Notes: Sticky state uses its own reset so hot reset keeps it
`timescale 1ns/1ps
`default_nettype none
module pxr_cap_regs
    import pxr_pkg::*;
#(
    parameter bit UPSTREAM = 1'b1   // Port is the upstream port
)
(
    input wire logic ref_clk_i,             // Core clock, 25 MHz
    input wire logic rst_n_i,               // Async reset, active low
    input wire logic sticky_rst_n_i,        // Sticky reset, active low
    input wire logic [11:0] addr_i,         // Register byte address
    input wire logic [31:0] wdata_i,        // Write data
    input wire logic wr_i,                  // Write strobe
    input wire logic rd_i,                  // Read strobe
    output logic [31:0] rdata_o,            // Read data, cycle after rd_i
    input wire logic err_report_i,          // Uncorrectable error event
    input wire logic [4:0] err_bit_i,       // Status bit of the error
    input wire logic [127:0] err_header_i,  // Offending packet header
    output logic [4:0] first_err_ptr_o      // First error pointer
);
    typedef struct packed {
        logic [31:0] rdata;
        logic lock;
        logic [11:0] sn_next;
        logic [11:0] vc_next;
    } pxr_bank_s;

    pxr_bank_s st_ff;
    pxr_bank_s nxt_st;
    logic [127:0] log_w;
    logic [4:0] fep_w;
    logic [63:0] id_w;
    logic wr_low_w;
    logic wr_high_w;
    logic [1:0] entry_size_w;
    logic [31:0] vc_one_w;

    // Only two of the four defined encodings apply to a port
    assign entry_size_w = UPSTREAM ? ENTRY_SIZE_4BIT
                                   : ENTRY_SIZE_1BIT;
    // Capability word one; reserved bits tied low
    assign vc_one_w = {20'h00000, entry_size_w, ARB_TIME_BASE,
                       1'b0, LOW_PRIO_CHAN_COUNT,
                       1'b0, EXT_CHAN_COUNT};

    assign wr_low_w = wr_i && (addr_i == OFS_SERIAL_LOW);
    assign wr_high_w = wr_i && (addr_i == OFS_SERIAL_HIGH);

    pxr_hdr_log u_hdr_log (
        .ref_clk_i(ref_clk_i),
        .sticky_rst_n_i(sticky_rst_n_i),
        .err_report_i(err_report_i),
        .err_bit_i(err_bit_i),
        .err_header_i(err_header_i),
        .log_o(log_w),
        .fep_o(fep_w)
    );

    pxr_serial_id u_serial_id (
        .ref_clk_i(ref_clk_i),
        .sticky_rst_n_i(sticky_rst_n_i),
        .lock_i(st_ff.lock),
        .wr_low_i(wr_low_w),
        .wr_high_i(wr_high_w),
        .wdata_i(wdata_i),
        .id_o(id_w)
    );

    // Read decode; unmapped addresses read zero
    function automatic logic [31:0] read_word(input logic [11:0] a,
                                              input pxr_bank_s s);
        logic [31:0] r;
        r = WORD_ZERO;
        unique case (a)
            OFS_HDR_LOG_DW1: r = log_w[31:0];
            OFS_HDR_LOG_DW2: r = log_w[63:32];
            OFS_HDR_LOG_DW3: r = log_w[95:64];
            OFS_HDR_LOG_DW4: r = log_w[127:96];
            OFS_SERIAL_HDR: r = cap_header(CAP_ID_SERIAL,
                                           s.sn_next);
            OFS_SERIAL_LOW: r = id_w[31:0];
            OFS_SERIAL_HIGH: r = id_w[63:32];
            OFS_VCHAN_HDR: r = cap_header(CAP_ID_VCHAN,
                                          s.vc_next);
            OFS_PORT_VCHAN_ONE: r = vc_one_w;
            OFS_BANK_CTRL: r = {19'h00000, fep_w, 7'h00, s.lock};
            default: r = WORD_ZERO;
        endcase
        read_word = r;
    endfunction : read_word

    // Write handling; constant and read-only words drop writes
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rdata = rd_i ? read_word(addr_i, st_ff) : WORD_ZERO;
        if (wr_i)
        begin
            unique case (addr_i)
                OFS_BANK_CTRL: nxt_st.lock = wdata_i[CTRL_LOCK_BIT];
                OFS_SERIAL_HDR:
                    if (!st_ff.lock)
                        nxt_st.sn_next = wdata_i[31:20];
                OFS_VCHAN_HDR:
                    if (!st_ff.lock)
                        nxt_st.vc_next = wdata_i[31:20];
                default: nxt_st.lock = st_ff.lock;
            endcase
        end
    end

    // Bus side state resets on the normal reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff.rdata <= WORD_ZERO;
            st_ff.lock <= 1'b0;
            st_ff.sn_next <= NEXT_PTR_RESET;
            st_ff.vc_next <= NEXT_PTR_RESET;
        end
        else
            st_ff <= nxt_st;
    end

    // Pointer is re-registered so the output leaves a flip-flop directly
    logic [4:0] fep_ff;
    always_ff @(posedge ref_clk_i or negedge sticky_rst_n_i)
    begin
        if (!sticky_rst_n_i)
            fep_ff <= FEP_ZERO;
        else
            fep_ff <= fep_w;
    end

    assign rdata_o = st_ff.rdata;
    assign first_err_ptr_o = fep_ff;

    chk_serial_hdr: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (rd_i && addr_i == OFS_SERIAL_HDR) |=>
            rdata_o[19:0] == 20'h10003)
        else $error("Serial header identifier or version wrong");
    chk_vchan_hdr: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (rd_i && addr_i == OFS_VCHAN_HDR) |=>
            rdata_o[19:0] == 20'h10002)
        else $error("Channel header identifier or version wrong");
    chk_vc_one: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (rd_i && addr_i == OFS_PORT_VCHAN_ONE) |=>
            rdata_o == (UPSTREAM ? 32'h0000_0800 : 32'h0000_0000))
        else $error("Port channel capability word wrong");
    chk_unmapped_zero: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (rd_i && addr_i == 12'h004) |=> rdata_o == 32'h0000_0000)
        else $error("Unmapped read not zero");
    chk_vc_next_rst: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        $rose(rst_n_i) |-> st_ff.vc_next == 12'h000)
        else $error("Next pointer not zero after reset");
    chk_log_read: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (rd_i && addr_i == OFS_HDR_LOG_DW3) |=>
            rdata_o == $past(log_w[95:64]))
        else $error("Header log word three read wrong");
endmodule : pxr_cap_regs
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the capability register bank
// Assumes: Both resets asserted together at power up
// Notes: An upstream and a downstream bank share one register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pxr_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sticky_rst_n_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic err_report_i = 1'b0;
    logic [4:0] err_bit_i = 5'h00;
    logic [127:0] err_header_i = 128'h0;
    logic [31:0] rdata_o;
    logic [31:0] rdata_dn;
    logic [4:0] first_err_ptr_o;
    logic [4:0] fep_dn;
    logic rd_q = 1'b0;
    logic [63:0] exp_q[$];
    int err_total = 0;
    int n_checks = 0;
    logic [31:0] id_lo;
    logic [31:0] id_hi;
    logic [127:0] hdr;
    logic [4:0] ebit;

    // Two banks differ only in the port kind, so one queue entry holds both
    pxr_cap_regs #(.UPSTREAM(1'b1)) dut (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .sticky_rst_n_i(sticky_rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .err_report_i(err_report_i),
        .err_bit_i(err_bit_i), .err_header_i(err_header_i),
        .first_err_ptr_o(first_err_ptr_o));
    pxr_cap_regs #(.UPSTREAM(1'b0)) dut_dn (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .sticky_rst_n_i(sticky_rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_dn), .err_report_i(err_report_i),
        .err_bit_i(err_bit_i), .err_header_i(err_header_i),
        .first_err_ptr_o(fep_dn));

    // Clock, 40 ns period
    initial
    begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    // Read data only stands one cycle, so sample it mid-cycle
    always @(posedge ref_clk_i) rd_q <= rd_i;
    always @(negedge ref_clk_i)
    begin
        if (rd_q)
            chk({rdata_dn, rdata_o}, exp_q.pop_front());
        else if (rst_n_i)
            chk({rdata_dn, rdata_o}, 64'h0);
    end

    // Bus tasks are entered at a rising edge and leave at the next one
    task automatic rd(input logic [11:0] a, input logic [31:0] e_up,
                      input logic [31:0] e_dn);
        exp_q.push_back({e_dn, e_up});
        addr_i <= a;
        wdata_i <= $urandom;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : rd

    task automatic rd1(input logic [11:0] a, input logic [31:0] e);
        rd(a, e, e);
    endtask : rd1

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : wr

    task automatic idle;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : idle

    // Error event, taken at the next edge; the bus stays free meanwhile
    task automatic err(input logic [4:0] b, input logic [127:0] h);
        // A read left standing would be taken again and pop an empty queue
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        err_report_i <= 1'b1;
        err_bit_i <= b;
        err_header_i <= h;
        @(posedge ref_clk_i);
        err_report_i <= 1'b0;
    endtask : err

    // Waits one edge first so a pending read result is still compared
    task automatic rst(input logic hot, input logic sticky);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge ref_clk_i);
        rst_n_i <= ~hot;
        sticky_rst_n_i <= ~sticky;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        sticky_rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask : rst

    // Watchdog at 4000 cycles, far beyond the fewer than 100 cycles the tests need
    initial
    begin
        #(4000 * 40);
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        void'($urandom(57));
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        sticky_rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        for (int i = 0; i < 4; i++)
            rd1(OFS_HDR_LOG_DW1 + 12'(4 * i), 32'h0);
        rd1(OFS_SERIAL_HDR, 32'h0001_0003);
        rd1(OFS_SERIAL_LOW, 32'h0);
        rd1(OFS_SERIAL_HIGH, 32'h0);
        rd1(OFS_VCHAN_HDR, 32'h0001_0002);
        rd(OFS_PORT_VCHAN_ONE, 32'h0000_0800, 32'h0);
        rd1(12'h3fc, 32'h0);
        rd1(12'h004, 32'h0);
        // Constant fields must shrug off all-ones writes
        for (int i = 0; i < 4; i++)
            wr(OFS_HDR_LOG_DW1 + 12'(4 * i), 32'hffff_ffff);
        wr(OFS_PORT_VCHAN_ONE, 32'hffff_ffff);
        wr(OFS_VCHAN_HDR, 32'hffff_ffff);
        rd1(OFS_VCHAN_HDR, 32'hfff1_0002);
        rd(OFS_PORT_VCHAN_ONE, 32'h0000_0800, 32'h0);
        rd1(OFS_HDR_LOG_DW4, 32'h0);
        wr(OFS_VCHAN_HDR, 32'h0);
        // Identifier halves, then the lock holds them
        id_lo = $urandom;
        id_hi = $urandom;
        wr(OFS_SERIAL_LOW, id_lo);
        wr(OFS_SERIAL_HIGH, id_hi);
        rd1(OFS_SERIAL_LOW, id_lo);
        rd1(OFS_SERIAL_HIGH, id_hi);
        wr(OFS_BANK_CTRL, 32'h1);
        wr(OFS_SERIAL_LOW, ~id_lo);
        wr(OFS_SERIAL_HIGH, ~id_hi);
        wr(OFS_SERIAL_HDR, 32'hfff0_0000);
        rd1(OFS_SERIAL_LOW, id_lo);
        rd1(OFS_SERIAL_HIGH, id_hi);
        rd1(OFS_SERIAL_HDR, 32'h0001_0003);
        idle();
        // First error is logged, a later one is not
        ebit = 5'($urandom);
        hdr = {$urandom, $urandom, $urandom, $urandom};
        err(ebit, hdr);
        for (int i = 0; i < 4; i++)
            rd1(OFS_HDR_LOG_DW1 + 12'(4 * i), hdr[32 * i +: 32]);
        err(~ebit, ~hdr);
        for (int i = 0; i < 4; i++)
            rd1(OFS_HDR_LOG_DW1 + 12'(4 * i), hdr[32 * i +: 32]);
        rd1(OFS_BANK_CTRL, {19'h0, ebit, 7'h0, 1'b1});
        idle();
        chk({59'h0, first_err_ptr_o}, {59'h0, ebit});
        chk({59'h0, fep_dn}, {59'h0, ebit});
        // Hot reset keeps sticky state but drops the lock
        rst(1'b1, 1'b0);
        rd1(OFS_BANK_CTRL, {19'h0, ebit, 8'h0});
        rd1(OFS_SERIAL_LOW, id_lo);
        rd1(OFS_SERIAL_HIGH, id_hi);
        rd1(OFS_HDR_LOG_DW2, hdr[63:32]);
        // Sticky reset clears log, pointer and identifier
        rst(1'b0, 1'b1);
        rd1(OFS_SERIAL_LOW, 32'h0);
        rd1(OFS_SERIAL_HIGH, 32'h0);
        for (int i = 0; i < 4; i++)
            rd1(OFS_HDR_LOG_DW1 + 12'(4 * i), 32'h0);
        rd1(OFS_BANK_CTRL, 32'h0);
        idle();
        chk({59'h0, first_err_ptr_o}, 64'h0);
        repeat (2) idle();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
